// file: core/srx_map.vh
`ifndef SRX_MAP_VH
`define SRX_MAP_VH

// aligner mode select codes (i_align_mode)
`define SRX_AM_BITSLIP 3'h0
`define SRX_AM_P16 3'h1
`define SRX_AM_P10 3'h2
`define SRX_AM_XAUI 3'h3
`define SRX_AM_GIGE 3'h4

// configuration codes (i_config)
`define SRX_CFG_CUSTOM 2'h0
`define SRX_CFG_SONET 2'h1
`define SRX_CFG_XAUI 2'h2
`define SRX_CFG_GIGE 2'h3

// equalizer and loop bandwidth
`define SRX_EQ_MAX 3'h4
`define SRX_BW_LOW 2'h0
`define SRX_BW_MED 2'h1
`define SRX_BW_HIGH 2'h2

// ppm threshold table, selected by i_ppm_sel
`define SRX_PPM_0 11'd125
`define SRX_PPM_1 11'd250
`define SRX_PPM_2 11'd500
`define SRX_PPM_3 11'd1000

// phase window in milli unit intervals (0.08 UI)
`define SRX_PHASE_MUI 8'd80

// run length step per path width
`define SRX_RUN_STEP10 8'd5
`define SRX_RUN_STEP8 8'd4
`define SRX_RUN_STEPS_MAX 6'd32

// comma code group, running disparity negative form, first bit in bit 0
`define SRX_K285 10'h17C

// protocol synchroniser thresholds
`define SRX_SYNC_GOOD 2'h3
`define SRX_SYNC_BAD 3'h4

// output fifo
`define SRX_FIFO_W 11
`define SRX_FIFO_D 8

`endif

// file: core/srx_fifo.v
`timescale 1ns/10ps
module srx_fifo #(
  parameter W = 11,
  parameter D = 8,
  parameter AW = 3
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_valid,
  input wire [W-1:0] i_data,
  output wire o_ready,
  output reg o_valid,
  output reg [W-1:0] o_data,
  input wire i_ready,
  output wire [AW:0] o_level
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] cnt;
  wire push;
  wire pop;

  assign o_ready = (cnt != D[AW:0]);
  assign o_level = cnt;
  assign push = i_valid && o_ready;
  // output stage refills whenever it is empty or being taken
  assign pop = (cnt != {(AW+1){1'b0}}) && (!o_valid || i_ready);

  always @(posedge i_clk) begin
    if (push) begin
      mem[wptr] <= i_data;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
      o_valid <= 1'b0;
      o_data <= {W{1'b0}};
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
        o_data <= mem[rptr];
        o_valid <= 1'b1;
      end else if (i_ready) begin
        o_valid <= 1'b0;
      end
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// file: core/srx_top.v
// Overview of operation
// - equalizer setting 0..4 taken at any time; higher boosts more
// - one recovery unit per channel; unused channel holds it powered down
// - active-low output shows pll locked to reference clock
// - loop bandwidth is a static choice of low, medium, high
// - auto mode leaves reference lock only within ppm threshold 125/250/500/1000
// - auto switch also needs phase match within 0.08 unit interval
// - run-length limit 5..160 step 5 (10-bit) or 4..128 step 4 (8-bit)
// - force-data wins; else force-reference; both low gives automatic
// - override inputs tied low give automatic lock-mode selection
// - frequency-lock output high while in data-lock mode
// - serial to 8- or 10-bit words, first bit lands in bit 0
// - modes: bit-slip, 16-bit, 10-bit, and two fixed protocol modes
// - each slip request moves the word boundary by exactly one bit
// - bit-slip on 8/10-bit paths, only in custom and sonet configs
// - bit-slip mode still flags the user pattern but never realigns
// - 16-bit mode aligns to two-byte or doubled pattern, 8-bit path only
// - doubled pattern allowed only in sonet, refused in custom
// - 16-bit mode realigns after the user realign request
// - 10-bit mode matches all ten bits or lower seven, as configured
// - 10-bit mode accepts both disparity forms of the pattern
// - 10-bit aligner moves only while enable held; custom config only
// - protocol modes align by state machine on the comma code group
`timescale 1ns/10ps
`include "srx_map.vh"
module srx_top (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_chan_used,
  input wire [2:0] i_eq_set,
  input wire [1:0] i_bw_sel,
  input wire [1:0] i_ppm_sel,
  input wire [10:0] i_freq_err_ppm,
  input wire [7:0] i_phase_err_mui,
  input wire i_lock_to_data,
  input wire i_lock_to_ref,
  input wire [5:0] i_run_steps,
  input wire [1:0] i_config,
  input wire [2:0] i_align_mode,
  input wire i_width10,
  input wire i_doubled,
  input wire i_match7,
  input wire [15:0] i_pattern,
  input wire i_slip,
  input wire i_realign,
  input wire i_align_en,
  input wire i_ser_valid,
  input wire i_ser_bit,
  input wire i_word_ready,
  output reg o_ser_ready,
  output reg o_cdr_pwrdn,
  output reg [2:0] o_eq_ctrl,
  output reg [1:0] o_bw_ctrl,
  output reg o_rx_locked_n,
  output reg o_freq_locked,
  output reg o_run_err,
  output reg o_mode_err,
  output reg o_sync,
  output wire o_word_valid,
  output wire [9:0] o_word,
  output wire o_pat_det,
  output wire [3:0] o_fifo_level
);
  localparam LK_REF = 2'b01;
  localparam LK_DATA = 2'b10;
  localparam PS_LOSS = 3'b001;
  localparam PS_ACQ = 3'b010;
  localparam PS_SYNC = 3'b100;

  reg [1:0] lk_state;
  reg [1:0] next_lk_state;
  reg [2:0] ps_state;
  reg [2:0] next_ps_state;
  reg [31:0] sr;
  reg [3:0] bcnt;
  reg slip_d;
  reg slip_pend;
  reg realign_d;
  reg realign_arm;
  reg [7:0] run_cnt;
  reg last_bit;
  reg [1:0] good_cnt;
  reg [2:0] bad_cnt;
  reg [10:0] ppm_lim;
  reg [7:0] run_lim;
  reg m_slip;
  reg m_p16;
  reg m_p10;
  reg m_proto;
  reg mode_bad;
  reg [9:0] upat;

  wire take_bit;
  wire [31:0] next_sr;
  wire [9:0] cand;
  wire [3:0] wlast;
  wire at_bound;
  wire freq_ok;
  wire phase_ok;
  wire hit10;
  wire hit16;
  wire comma;
  wire det;
  wire align_now;
  wire emit;
  wire fifo_ready;
  wire [`SRX_FIFO_W-1:0] fifo_out;
  wire [3:0] lvl;
  wire [9:0] p10n;

  assign take_bit = i_ser_valid && o_ser_ready && i_chan_used;
  assign next_sr = {i_ser_bit, sr[31:1]};
  assign cand = i_width10 ? next_sr[31:22] : {2'h0, next_sr[31:24]};
  assign wlast = i_width10 ? 4'h9 : 4'h7;
  assign at_bound = (bcnt == wlast);
  assign freq_ok = (i_freq_err_ppm <= ppm_lim);
  assign phase_ok = (i_phase_err_mui <= `SRX_PHASE_MUI);

  // negative disparity form is the bitwise inverse of the positive one
  assign p10n = ~i_pattern[9:0];
  assign hit10 = i_match7 ?
    ((cand[6:0] == i_pattern[6:0]) || (cand[6:0] == p10n[6:0])) :
    ((cand == i_pattern[9:0]) || (cand == p10n));
  // two-byte form ends with the second byte in the top byte
  assign hit16 = i_doubled ?
    (next_sr == {i_pattern[15:8], i_pattern[15:8], i_pattern[7:0], i_pattern[7:0]}) :
    (next_sr[31:16] == i_pattern);
  assign comma = (cand == `SRX_K285) || (cand == ~`SRX_K285);

  always @* begin
    upat = i_width10 ? i_pattern[9:0] : {2'h0, i_pattern[7:0]};
  end

  assign det = (m_slip && (cand == upat)) ||
               (m_p16 && hit16) ||
               (m_p10 && hit10) ||
               (m_proto && comma);

  // boundary forcing: 10-bit needs the enable held, 16-bit needs the arm set by reset or a request
  assign align_now = (m_p16 && realign_arm && hit16) ||
                     (m_p10 && i_align_en && hit10) ||
                     (m_proto && ps_state == PS_LOSS && comma);
  assign emit = take_bit && !slip_pend && (at_bound || align_now);

  // mode legality against configuration and path width
  always @* begin
    m_slip = 1'b0;
    m_p16 = 1'b0;
    m_p10 = 1'b0;
    m_proto = 1'b0;
    mode_bad = 1'b0;
    case (i_align_mode)
      `SRX_AM_BITSLIP: begin
        mode_bad = (i_config != `SRX_CFG_CUSTOM) && (i_config != `SRX_CFG_SONET);
      end
      `SRX_AM_P16: begin
        mode_bad = i_width10 ||
          ((i_config != `SRX_CFG_CUSTOM) && (i_config != `SRX_CFG_SONET)) ||
          (i_doubled && (i_config != `SRX_CFG_SONET));
      end
      `SRX_AM_P10: begin
        mode_bad = !i_width10 || (i_config != `SRX_CFG_CUSTOM);
      end
      `SRX_AM_XAUI: begin
        mode_bad = !i_width10 || (i_config != `SRX_CFG_XAUI);
      end
      `SRX_AM_GIGE: begin
        mode_bad = !i_width10 || (i_config != `SRX_CFG_GIGE);
      end
      default: begin
        mode_bad = 1'b1;
      end
    endcase
    if (!mode_bad) begin
      m_slip = (i_align_mode == `SRX_AM_BITSLIP);
      m_p16 = (i_align_mode == `SRX_AM_P16);
      m_p10 = (i_align_mode == `SRX_AM_P10);
      m_proto = (i_align_mode == `SRX_AM_XAUI) || (i_align_mode == `SRX_AM_GIGE);
    end
  end

  always @* begin
    case (i_ppm_sel)
      2'h0: ppm_lim = `SRX_PPM_0;
      2'h1: ppm_lim = `SRX_PPM_1;
      2'h2: ppm_lim = `SRX_PPM_2;
      default: ppm_lim = `SRX_PPM_3;
    endcase
  end

  // zero steps is read as one step so the limit is never zero
  always @* begin
    if (i_run_steps == 6'h0) begin
      run_lim = i_width10 ? `SRX_RUN_STEP10 : `SRX_RUN_STEP8;
    end else if (i_run_steps > `SRX_RUN_STEPS_MAX) begin
      run_lim = i_width10 ? 8'd160 : 8'd128;
    end else begin
      run_lim = i_width10 ? (i_run_steps * `SRX_RUN_STEP10) :
                            (i_run_steps * `SRX_RUN_STEP8);
    end
  end

  always @* begin
    next_lk_state = lk_state;
    if (i_lock_to_data) begin
      next_lk_state = LK_DATA;
    end else if (i_lock_to_ref) begin
      next_lk_state = LK_REF;
    end else begin
      case (lk_state)
        LK_REF: begin
          if (freq_ok && phase_ok) begin
            next_lk_state = LK_DATA;
          end
        end
        LK_DATA: begin
          if (!freq_ok) begin
            next_lk_state = LK_REF;
          end
        end
        default: begin
          next_lk_state = LK_REF;
        end
      endcase
    end
  end

  always @* begin
    next_ps_state = ps_state;
    if (!m_proto) begin
      next_ps_state = PS_LOSS;
    end else if (emit) begin
      case (ps_state)
        PS_LOSS: begin
          if (comma) begin
            next_ps_state = PS_ACQ;
          end
        end
        PS_ACQ: begin
          if (comma && !at_bound) begin
            next_ps_state = PS_LOSS;
          end else if (comma && good_cnt == `SRX_SYNC_GOOD - 2'h1) begin
            next_ps_state = PS_SYNC;
          end
        end
        PS_SYNC: begin
          if (comma && !at_bound && bad_cnt == `SRX_SYNC_BAD - 3'h1) begin
            next_ps_state = PS_LOSS;
          end
        end
        default: begin
          next_ps_state = PS_LOSS;
        end
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n || !i_chan_used) begin
      lk_state <= LK_REF;
      ps_state <= PS_LOSS;
      sr <= 32'h0;
      bcnt <= 4'h0;
      slip_d <= 1'b0;
      slip_pend <= 1'b0;
      realign_d <= 1'b0;
      realign_arm <= 1'b1;
      run_cnt <= 8'h0;
      last_bit <= 1'b0;
      good_cnt <= 2'h0;
      bad_cnt <= 3'h0;
      o_rx_locked_n <= 1'b1;
      o_freq_locked <= 1'b0;
      o_run_err <= 1'b0;
      o_sync <= 1'b0;
      o_ser_ready <= 1'b0;
    end else begin
      lk_state <= next_lk_state;
      ps_state <= next_ps_state;
      o_freq_locked <= (next_lk_state == LK_DATA);
      o_rx_locked_n <= !(next_lk_state == LK_REF && freq_ok && phase_ok);
      o_sync <= (next_ps_state == PS_SYNC);
      // words come no closer than eight bits, so two free slots suffice
      // a forced boundary can emit sooner, so the full flag is folded in;
      // a word that meets a full fifo is lost, the sender must respect ready
      o_ser_ready <= (lvl <= 4'd6) && fifo_ready;
      slip_d <= i_slip;
      realign_d <= i_realign;
      if (m_slip && i_slip && !slip_d) begin
        slip_pend <= 1'b1;
      end else if (take_bit) begin
        slip_pend <= 1'b0;
      end
      if (i_realign && !realign_d) begin
        realign_arm <= 1'b1;
      end else if (emit && m_p16 && hit16) begin
        realign_arm <= 1'b0;
      end
      if (take_bit) begin
        sr <= next_sr;
        last_bit <= i_ser_bit;
        // a slip swallows one taken bit, so the next word ends one bit later
        if (slip_pend) begin
          bcnt <= bcnt;
        end else if (emit) begin
          bcnt <= 4'h0;
        end else begin
          bcnt <= bcnt + 4'h1;
        end
        if (i_ser_bit == last_bit) begin
          if (run_cnt != 8'hFF) begin
            run_cnt <= run_cnt + 8'h1;
          end
        end else begin
          run_cnt <= 8'h1;
        end
        o_run_err <= (i_ser_bit == last_bit) && (run_cnt >= run_lim);
      end
      if (emit && m_proto) begin
        if (ps_state == PS_ACQ && comma && at_bound) begin
          good_cnt <= good_cnt + 2'h1;
        end else if (ps_state != PS_ACQ) begin
          good_cnt <= 2'h0;
        end
        if (ps_state == PS_SYNC && comma && !at_bound) begin
          bad_cnt <= bad_cnt + 3'h1;
        end else if (ps_state != PS_SYNC || (comma && at_bound)) begin
          bad_cnt <= 3'h0;
        end
      end
    end
  end

  // static-style settings still follow the inputs every cycle
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_cdr_pwrdn <= 1'b1;
      o_eq_ctrl <= 3'h0;
      o_bw_ctrl <= `SRX_BW_MED;
      o_mode_err <= 1'b0;
    end else begin
      o_cdr_pwrdn <= !i_chan_used;
      o_eq_ctrl <= (i_eq_set > `SRX_EQ_MAX) ? `SRX_EQ_MAX : i_eq_set;
      o_bw_ctrl <= (i_bw_sel == 2'h3) ? `SRX_BW_MED : i_bw_sel;
      o_mode_err <= mode_bad;
    end
  end

  // the detect flag rides in the top bit of each fifo entry
  srx_fifo #(
    .W(`SRX_FIFO_W),
    .D(`SRX_FIFO_D),
    .AW(3)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(emit),
    .i_data({det, cand}),
    .o_ready(fifo_ready),
    .o_valid(o_word_valid),
    .o_data(fifo_out),
    .i_ready(i_word_ready),
    .o_level(lvl)
  );

  assign o_word = fifo_out[9:0];
  assign o_pat_det = fifo_out[10];
  assign o_fifo_level = lvl;
endmodule

// file: tb/srx_chk.sv
`timescale 1ns/10ps
`include "srx_map.vh"
module srx_chk (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_chan_used,
  input wire [2:0] i_eq_set,
  input wire [1:0] i_ppm_sel,
  input wire [10:0] i_freq_err_ppm,
  input wire i_lock_to_data,
  input wire i_lock_to_ref,
  input wire [1:0] i_config,
  input wire [2:0] i_align_mode,
  input wire i_doubled,
  input wire i_word_ready,
  input wire o_cdr_pwrdn,
  input wire [2:0] o_eq_ctrl,
  input wire o_rx_locked_n,
  input wire o_freq_locked,
  input wire o_mode_err,
  input wire o_word_valid,
  input wire [9:0] o_word,
  input wire o_pat_det
);
  wire [10:0] thr = i_ppm_sel[1] ? (i_ppm_sel[0] ? 11'h3E8 : 11'h1F4) :
    (i_ppm_sel[0] ? 11'h0FA : 11'h07D);
  wire cu = i_chan_used;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_unused_pwrdn: assert property (!cu |=> o_cdr_pwrdn)
    else $error("unused recovery unit not powered down");
  a_eq_clamp: assert property (
    $past(i_rst_n) && $stable(i_eq_set) |-> o_eq_ctrl == (i_eq_set > 3'h4 ? 3'h4 : i_eq_set))
    else $error("equalizer setting wrong");
  a_lock_excl: assert property (!(o_freq_locked && !o_rx_locked_n))
    else $error("ref lock and data lock shown together");
  a_force_data: assert property ((i_lock_to_data && cu) [*3] |-> o_freq_locked)
    else $error("force data not obeyed");
  a_force_ref: assert property (
    (!i_lock_to_data && i_lock_to_ref && cu) [*3] |-> !o_freq_locked)
    else $error("force reference not obeyed");
  a_ppm_gate: assert property (
    (!i_lock_to_data && !i_lock_to_ref && cu && i_freq_err_ppm > thr) [*3] |-> !o_freq_locked)
    else $error("data lock outside ppm threshold");
  a_word_hold: assert property (
    o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word) && $stable(o_pat_det))
    else $error("output word changed while stalled");
  a_doubled_custom: assert property ((cu && i_config == `SRX_CFG_CUSTOM &&
    i_align_mode == `SRX_AM_P16 && i_doubled) [*2] |-> o_mode_err)
    else $error("doubled pattern accepted in custom");
  a_p10_sonet: assert property (
    (cu && i_config == `SRX_CFG_SONET && i_align_mode == `SRX_AM_P10) [*2] |-> o_mode_err)
    else $error("10-bit mode accepted outside custom");
  a_slip_cfg: assert property (
    (cu && i_config == `SRX_CFG_XAUI && i_align_mode == `SRX_AM_BITSLIP) [*2] |-> o_mode_err)
    else $error("bit-slip accepted in protocol config");
endmodule

// file: tb/srx_tx_model.sv
`timescale 1ns/10ps
module srx_tx_model (
  input wire i_clk,
  input wire i_ready,
  output logic o_valid,
  output logic o_bit
);
  initial begin
    o_valid = 1'b0;
    o_bit = 1'b0;
  end
  task automatic send(input logic [9:0] w, input int n, input bit last = 1'b1);
    int i;
    int k;
    for (i = 0; i < n; i++) begin
      o_valid <= 1'b1;
      o_bit <= w[i];
      k = 0;
      do begin
        @(posedge i_clk);
        k++;
      end while (!i_ready && k < 64);
    end
    // back-to-back sends keep valid up instead of dropping it for no time
    if (last) begin
      o_valid <= 1'b0;
      // idle line must not keep showing the last bit
      o_bit <= ~w[n-1];
    end
  endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
`include "srx_map.vh"
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n, i_chan_used, i_lock_to_data, i_lock_to_ref, i_width10, i_doubled;
  logic i_slip, i_align_en, i_word_ready, i_match7, i_realign;
  logic [2:0] i_eq_set, i_align_mode;
  logic [1:0] i_bw_sel, i_ppm_sel, i_config;
  logic [10:0] i_freq_err_ppm;
  logic [7:0] i_phase_err_mui;
  logic [5:0] i_run_steps;
  logic [15:0] i_pattern;
  wire ser_valid, ser_bit, o_ser_ready, o_cdr_pwrdn, o_rx_locked_n, o_freq_locked;
  wire o_run_err, o_mode_err, o_sync, o_word_valid, o_pat_det;
  wire [2:0] o_eq_ctrl;
  wire [1:0] o_bw_ctrl;
  wire [9:0] o_word;
  wire [3:0] o_fifo_level;
  logic [15:0] rq[$];
  int fail_count = 0;
  int tests_run = 0;
  logic [10:0] thr_t [4] = '{11'h07D, 11'h0FA, 11'h1F4, 11'h3E8};
  // {config, mode, width10, doubled, expected error}
  logic [7:0] mt [9] = '{8'h0B, 8'h4A, 8'h55, 8'h14, 8'h85, 8'h44, 8'h0D, 8'hE4, 8'h9C};
  always #25 i_clk = ~i_clk;
  srx_top dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_chan_used(i_chan_used), .i_eq_set(i_eq_set),
    .i_bw_sel(i_bw_sel), .i_ppm_sel(i_ppm_sel), .i_freq_err_ppm(i_freq_err_ppm),
    .i_phase_err_mui(i_phase_err_mui), .i_lock_to_data(i_lock_to_data),
    .i_lock_to_ref(i_lock_to_ref), .i_run_steps(i_run_steps), .i_config(i_config),
    .i_align_mode(i_align_mode), .i_width10(i_width10), .i_doubled(i_doubled),
    .i_match7(i_match7), .i_pattern(i_pattern), .i_slip(i_slip), .i_realign(i_realign),
    .i_align_en(i_align_en), .i_ser_valid(ser_valid), .i_ser_bit(ser_bit),
    .i_word_ready(i_word_ready), .o_ser_ready(o_ser_ready), .o_cdr_pwrdn(o_cdr_pwrdn),
    .o_eq_ctrl(o_eq_ctrl), .o_bw_ctrl(o_bw_ctrl), .o_rx_locked_n(o_rx_locked_n),
    .o_freq_locked(o_freq_locked), .o_run_err(o_run_err), .o_mode_err(o_mode_err),
    .o_sync(o_sync), .o_word_valid(o_word_valid), .o_word(o_word), .o_pat_det(o_pat_det),
    .o_fifo_level(o_fifo_level)
  );
  srx_tx_model tx_u (.i_clk(i_clk), .i_ready(o_ser_ready), .o_valid(ser_valid), .o_bit(ser_bit));
  always @(posedge i_clk) begin
    if (o_word_valid && i_word_ready) begin
      rq.push_back({5'h00, o_pat_det, o_word});
    end
  end
  task automatic print_verdict;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic c1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic rst;
    i_rst_n <= 1'b0;
    cyc(12);
    i_rst_n <= 1'b1;
    cyc(2);
    rq.delete();
  endtask
  // mask drops the detect flag where a pattern straddles two words
  task automatic word(input logic [10:0] e, input logic [10:0] m);
    int k;
    for (k = 0; k < 60 && rq.size() == 0; k++) @(posedge i_clk);
    if (rq.size() == 0) begin
      fail_count++;
      print_verdict;
    end
    chk(rq.pop_front() & {5'h00, m}, {5'h00, e});
  endtask
  task automatic t_ctrl;
    int v;
    for (v = 0; v < 8; v++) begin
      i_eq_set <= v[2:0];
      i_bw_sel <= v[1:0];
      cyc(3);
      chk({13'h0000, o_eq_ctrl}, (v > 4) ? 16'h0004 : v[15:0]);
      chk({14'h0000, o_bw_ctrl}, (v[1:0] == 2'h3) ? 16'h0001 : {14'h0000, v[1:0]});
    end
    i_chan_used <= 1'b0;
    cyc(3);
    c1(o_cdr_pwrdn, 1'b1);
    i_chan_used <= 1'b1;
    cyc(3);
    c1(o_cdr_pwrdn, 1'b0);
    $display("t_ctrl done");
  endtask
  task automatic t_lock;
    int s;
    for (s = 0; s < 4; s++) begin
      i_ppm_sel <= s[1:0];
      i_phase_err_mui <= 8'h50;
      i_freq_err_ppm <= thr_t[s] + 11'h001;
      cyc(4);
      c1(o_freq_locked, 1'b0);
      i_phase_err_mui <= 8'h51;
      i_freq_err_ppm <= thr_t[s];
      cyc(4);
      c1(o_freq_locked, 1'b0);
      i_phase_err_mui <= 8'h50;
      cyc(4);
      c1(o_freq_locked, 1'b1);
      i_freq_err_ppm <= thr_t[s] + 11'h001;
      cyc(4);
      c1(o_freq_locked, 1'b0);
    end
    i_freq_err_ppm <= 11'h010;
    i_lock_to_ref <= 1'b1;
    cyc(4);
    c1(o_freq_locked, 1'b0);
    c1(o_rx_locked_n, 1'b0);
    i_freq_err_ppm <= 11'h7FF;
    i_lock_to_data <= 1'b1;
    cyc(4);
    c1(o_freq_locked, 1'b1);
    i_lock_to_data <= 1'b0;
    i_lock_to_ref <= 1'b0;
    cyc(4);
    c1(o_freq_locked, 1'b0);
    $display("t_lock done");
  endtask
  task automatic t_mode;
    int i;
    for (i = 0; i < 9; i++) begin
      {i_config, i_align_mode, i_width10, i_doubled} <= mt[i][7:1];
      cyc(3);
      c1(o_mode_err, mt[i][0]);
    end
    $display("t_mode done");
  endtask
  task automatic t_slip;
    {i_config, i_align_mode, i_width10, i_doubled} <= 7'h02;
    rst;
    tx_u.send(10'h0F3, 10);
    word(11'h4F3, 11'h7FF);
    i_slip <= 1'b1;
    cyc(3);
    i_slip <= 1'b0;
    tx_u.send(10'h001, 1, 1'b0);
    tx_u.send(10'h155, 10);
    word(11'h155, 11'h7FF);
    $display("t_slip done");
  endtask
  task automatic t_p10;
    i_align_mode <= `SRX_AM_P10;
    i_pattern <= 16'h017C;
    i_align_en <= 1'b1;
    rst;
    tx_u.send(10'h2AA, 3, 1'b0);
    tx_u.send(10'h283, 10);
    word(11'h01A, 11'h7FF);
    word(11'h683, 11'h7FF);
    i_align_en <= 1'b0;
    tx_u.send(10'h2AA, 3, 1'b0);
    tx_u.send(10'h17C, 10, 1'b0);
    tx_u.send(10'h155, 7);
    word(11'h3E2, 11'h3FF);
    word(11'h2AA, 11'h3FF);
    // low seven bits match; only bit 9 differs from the pattern
    i_match7 <= 1'b1;
    rst;
    tx_u.send(10'h37C, 10);
    word(11'h77C, 11'h7FF);
    i_match7 <= 1'b0;
    $display("t_p10 done");
  endtask
  task automatic t_run;
    i_align_mode <= `SRX_AM_BITSLIP;
    i_run_steps <= 6'h02;
    rst;
    tx_u.send(10'h3FF, 10);
    cyc(2);
    c1(o_run_err, 1'b0);
    tx_u.send(10'h001, 1);
    cyc(2);
    c1(o_run_err, 1'b1);
    i_width10 <= 1'b0;
    i_run_steps <= 6'h01;
    rst;
    tx_u.send(10'h00F, 4);
    cyc(2);
    c1(o_run_err, 1'b0);
    tx_u.send(10'h001, 1);
    cyc(2);
    c1(o_run_err, 1'b1);
    i_width10 <= 1'b1;
    $display("t_run done");
  endtask
  task automatic t_fifo;
    int k;
    rst;
    i_word_ready <= 1'b0;
    for (k = 0; k < 8; k++) tx_u.send(10'h100 + k[9:0], 10, k == 7);
    cyc(3);
    chk({12'h000, o_fifo_level}, 16'h0007);
    c1(o_ser_ready, 1'b0);
    i_word_ready <= 1'b1;
    for (k = 0; k < 8; k++) word(11'h100 + k[10:0], 11'h3FF);
    chk({12'h000, o_fifo_level}, 16'h0000);
    $display("t_fifo done");
  endtask
  task automatic t_sync;
    int k;
    {i_config, i_align_mode} <= {`SRX_CFG_GIGE, `SRX_AM_GIGE};
    rst;
    tx_u.send(10'h2AA, 3, 1'b0);
    for (k = 0; k < 4; k++) tx_u.send(10'h17C, 10, k == 3);
    cyc(3);
    c1(o_sync, 1'b1);
    $display("t_sync done");
  endtask
  task automatic t_p16;
    {i_config, i_align_mode, i_width10, i_doubled} <= 7'h04;
    i_pattern <= 16'h28F6;
    rst;
    tx_u.send(10'h005, 3, 1'b0);
    tx_u.send(10'h0F6, 8, 1'b0);
    tx_u.send(10'h028, 8);
    word(11'h0B5, 11'h7FF);
    word(11'h047, 11'h7FF);
    word(11'h428, 11'h7FF);
    // disarmed now: the pattern passes without moving the boundary
    tx_u.send(10'h005, 3, 1'b0);
    tx_u.send(10'h0F6, 8, 1'b0);
    tx_u.send(10'h028, 8);
    word(11'h0B5, 11'h7FF);
    word(11'h047, 11'h7FF);
    i_realign <= 1'b1;
    cyc(2);
    i_realign <= 1'b0;
    tx_u.send(10'h0F6, 8, 1'b0);
    tx_u.send(10'h028, 8);
    word(11'h0B1, 11'h7FF);
    word(11'h047, 11'h7FF);
    word(11'h428, 11'h7FF);
    $display("t_p16 done");
  endtask
  initial begin
    {i_rst_n, i_slip, i_doubled, i_lock_to_data, i_lock_to_ref, i_align_en} = 6'h00;
    {i_match7, i_realign} = 2'h0;
    {i_eq_set, i_bw_sel, i_ppm_sel, i_config, i_align_mode} = 12'h000;
    {i_chan_used, i_word_ready, i_width10} = 3'h7;
    i_freq_err_ppm = 11'h7FF;
    i_phase_err_mui = 8'hFF;
    i_run_steps = 6'h01;
    i_pattern = 16'h00F3;
    cyc(11);
    c1(o_cdr_pwrdn, 1'b1);
    c1(o_rx_locked_n, 1'b1);
    c1(o_freq_locked, 1'b0);
    cyc(1);
    i_rst_n <= 1'b1;
    cyc(2);
    t_ctrl;
    t_lock;
    t_mode;
    t_slip;
    t_p10;
    t_run;
    t_fifo;
    t_sync;
    t_p16;
    print_verdict;
  end
  initial begin
    repeat (90000) @(posedge i_clk);
    fail_count++;
    print_verdict;
  end
endmodule
bind srx_top srx_chk chk_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_chan_used(i_chan_used), .i_eq_set(i_eq_set),
  .i_ppm_sel(i_ppm_sel), .i_freq_err_ppm(i_freq_err_ppm), .i_lock_to_data(i_lock_to_data),
  .i_lock_to_ref(i_lock_to_ref), .i_config(i_config), .i_align_mode(i_align_mode),
  .i_doubled(i_doubled), .i_word_ready(i_word_ready), .o_cdr_pwrdn(o_cdr_pwrdn),
  .o_eq_ctrl(o_eq_ctrl), .o_rx_locked_n(o_rx_locked_n), .o_freq_locked(o_freq_locked),
  .o_mode_err(o_mode_err), .o_word_valid(o_word_valid), .o_word(o_word), .o_pat_det(o_pat_det)
);
